// [hdl/vls_unit.sv]
// vector structure load/store unit with AXI4-Lite registers and a byte memory port
//
// Behaviour
// (R1) structures hold one to four elements; pattern equals element count and memory stride
// (R2) structure elements are 8, 16 or 32 bits, all equal within one structure
// (R3) a transfer names up to four 64-bit registers, count checked against pattern
// (R4) pattern one fills one to four registers with consecutive memory, no de-interleave
// (R5) pattern two fills two or four registers, even elements first group, odd second
// (R6) pattern three sends element k of every structure to register k
// (R7) pattern four sends each of four element positions to its own register
// (R8) pattern two, 16-bit, two registers: four lanes each, adjacent pairs split
// (R9) pattern two, 32-bit: same bytes moved, two lanes per register, even/odd kept
// (R10) bytes within an element are ordered by element size and selected endianness
// (R11) software should align the first element address to the element size
// (R12) all-lanes load fills every lane with successive distinct memory elements
// (R13) replicate load copies one structure element into every lane of its register
// (R14) single-lane load writes only the selected lane, other lanes stay unchanged
// (R15) stores re-interleave lanes into structure order, multiple-lane and single-lane forms
// (R16) plain addressing uses the base address and leaves the base unchanged
// (R17) increment-after adds the exact bytes transferred to the base when done
// (R18) post-index adds the index register to the base after the access
// (R19) every addressing form accepts an alignment qualifier on the base address
// (R20) single-register transfer moves one vector register as one 64-bit value
// (R21) block transfer moves consecutive vector registers, each a 64-bit value
// (R22) element j of structure i sits at base+(i*n+j)*s, lane i of register j
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module vls_unit import vls_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        vls_state_e_t state;
        logic [31:0] cfg, base, index, addr, xbase, wdata, rdata;
        logic [3:0] vsel, wstrb;
        logic done, align_fault, bad_cfg, aw_got, w_got, bvalid, rvalid;
        logic [2:0] b, i;
        logic [1:0] j, grp, bresp, rresp;
        logic [5:0] cnt, acks;
        logic [7:0] wbyte, awaddr;
        logic [VLS_NUM_VREG-1:0][VLS_VREG_BITS-1:0] vreg;
    } vls_regs_t;

    vls_regs_t st_reg;
    vls_regs_t st_next;

    function automatic logic [31:0] vls_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                r[k*8 +: 8] = new_v[k*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // decode of the active configuration
    // ****************************************
    logic op_store, bigend, is_struct, multi, cfg_ok, align_bad, start_req;
    vls_kind_t kind;
    vls_lane_t lmode;
    vls_amode_t amode;
    logic [1:0] pat, size, cntf, rd_resp;
    logic [2:0] lidx, align, n_el, nregs, grp_regs, eb, slot;
    logic [3:0] first, s_bytes, lanes, cur_reg;
    logic [5:0] total, bitpos;
    logic [31:0] rd_word;

    assign op_store = st_reg.cfg[CFG_STORE];
    assign kind = vls_kind_t'(st_reg.cfg[CFG_KIND_LSB +: 2]);
    assign lmode = vls_lane_t'(st_reg.cfg[CFG_LANE_LSB +: 2]);
    assign amode = vls_amode_t'(st_reg.cfg[CFG_AMODE_LSB +: 2]);
    assign pat = st_reg.cfg[CFG_PAT_LSB +: 2];
    assign size = st_reg.cfg[CFG_SIZE_LSB +: 2];
    assign lidx = st_reg.cfg[CFG_LIDX_LSB +: 3];
    assign cntf = st_reg.cfg[CFG_CNT_LSB +: 2];
    assign align = st_reg.cfg[CFG_ALIGN_LSB +: 3];
    assign bigend = st_reg.cfg[CFG_BIGEND];
    assign first = st_reg.cfg[CFG_FIRST_LSB +: 4];
    assign is_struct = (kind == VLS_KIND_STRUCT);
    // whole-register transfers are pattern one with a single 64-bit lane
    assign multi = !is_struct || (lmode == VLS_LANE_ALL); // R20 R21
    assign n_el = is_struct ? 3'({1'b0, pat} + 3'h1) : 3'h1; // R1
    assign s_bytes = is_struct ? 4'(4'h1 << size) : 4'h8; // R2 R20
    assign lanes = is_struct ? 4'(4'h8 >> size) : 4'h1;
    assign nregs = (kind == VLS_KIND_SINGLE) ? 3'h1 : 3'({1'b0, cntf} + 3'h1);
    assign grp_regs = (n_el == 3'h1) ? nregs : ((n_el == 3'h2) ? 3'(nregs >> 1) : 3'h1); // R5
    assign total = multi ? {nregs, 3'b000} : 6'(n_el * s_bytes);

    always_comb begin
        cfg_ok = (amode != 2'h3) && (kind != 2'h3) && (5'(first) + 5'(nregs) <= 5'(VLS_NUM_VREG));
        if (is_struct) begin
            if (size == 2'h3 || lmode == 2'h3) begin
                cfg_ok = 1'b0; // R2
            end
            if (multi) begin
                case (pat)
                    2'h0: cfg_ok = cfg_ok; // R4
                    2'h1: cfg_ok = cfg_ok && (nregs == 3'h2 || nregs == 3'h4); // R5
                    2'h2: cfg_ok = cfg_ok && (nregs == 3'h3); // R6
                    default: cfg_ok = cfg_ok && (nregs == 3'h4); // R7
                endcase
            end else begin
                cfg_ok = cfg_ok && (cntf == pat); // R3
            end
            if (lmode == VLS_LANE_ONE && 4'(lidx) >= lanes) begin
                cfg_ok = 1'b0; // R14
            end
            // a replicated store has no meaning
            if (lmode == VLS_LANE_REPL && op_store) begin
                cfg_ok = 1'b0; // R15
            end
        end
    end

    // the qualifier names a power-of-two byte boundary; a mismatch is refused
    assign align_bad = (align != 3'h0) && ((st_reg.base & ((32'h1 << align) - 32'h1)) != 32'h0); // R19

    // lane i of register j, groups of registers for pattern one and two
    assign cur_reg = 4'(first + 4'(st_reg.j * grp_regs) + 4'(st_reg.grp)); // R22 R5 R6 R7
    assign eb = bigend ? 3'(s_bytes - 4'h1 - 4'(st_reg.b)) : st_reg.b; // R10
    assign slot = multi ? 3'(st_reg.i * s_bytes + 4'(eb))
                        : 3'(((lmode == VLS_LANE_ONE) ? lidx : 3'h0) * s_bytes + 4'(eb)); // R14
    assign bitpos = {slot, 3'b000};

    // ****************************************
    // register read mux
    // ****************************************
    always_comb begin
        rd_resp = VLS_RESP_OKAY;
        case (s_axi_araddr)
            VLS_OFF_CFG: rd_word = st_reg.cfg;
            VLS_OFF_START: rd_word = 32'h0000_0000;
            VLS_OFF_STATUS: rd_word = {28'h000_0000, st_reg.bad_cfg, st_reg.align_fault, st_reg.done,
                                       st_reg.state != VLS_S_IDLE};
            VLS_OFF_BASE: rd_word = st_reg.base;
            VLS_OFF_INDEX: rd_word = st_reg.index;
            VLS_OFF_VSEL: rd_word = {28'h000_0000, st_reg.vsel};
            VLS_OFF_VLO: rd_word = st_reg.vreg[st_reg.vsel][31:0];
            VLS_OFF_VHI: rd_word = st_reg.vreg[st_reg.vsel][63:32];
            default: begin
                rd_word = 32'h0000_0000;
                rd_resp = VLS_RESP_SLVERR;
            end
        endcase
    end

    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign mem_req = (st_reg.state == VLS_S_XFER);
    assign mem_we = op_store;
    assign mem_addr = st_reg.addr;
    assign mem_wdata = st_reg.wbyte;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic idle;
        idle = (st_reg.state == VLS_S_IDLE);
        st_next = st_reg;
        start_req = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = VLS_RESP_OKAY;
            // setup registers are frozen while a transfer runs
            case (st_reg.awaddr)
                VLS_OFF_CFG: if (idle) st_next.cfg = vls_strb(st_reg.cfg, st_reg.wdata, st_reg.wstrb);
                VLS_OFF_START: start_req = st_reg.wdata[0] && st_reg.wstrb[0];
                VLS_OFF_STATUS: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.done = st_reg.done && !st_reg.wdata[ST_DONE];
                        st_next.align_fault = st_reg.align_fault && !st_reg.wdata[ST_ALIGN];
                        st_next.bad_cfg = st_reg.bad_cfg && !st_reg.wdata[ST_BAD];
                    end
                end
                VLS_OFF_BASE: if (idle) st_next.base = vls_strb(st_reg.base, st_reg.wdata, st_reg.wstrb);
                VLS_OFF_INDEX: if (idle) st_next.index = vls_strb(st_reg.index, st_reg.wdata, st_reg.wstrb);
                VLS_OFF_VSEL: if (st_reg.wstrb[0]) st_next.vsel = st_reg.wdata[3:0];
                VLS_OFF_VLO: begin
                    if (idle) begin
                        st_next.vreg[st_reg.vsel][31:0] =
                            vls_strb(st_reg.vreg[st_reg.vsel][31:0], st_reg.wdata, st_reg.wstrb);
                    end
                end
                VLS_OFF_VHI: begin
                    if (idle) begin
                        st_next.vreg[st_reg.vsel][63:32] =
                            vls_strb(st_reg.vreg[st_reg.vsel][63:32], st_reg.wdata, st_reg.wstrb);
                    end
                end
                default: st_next.bresp = VLS_RESP_SLVERR;
            endcase
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word;
            st_next.rresp = rd_resp;
        end

        // flag sets come after the software clears so that a set wins
        case (st_reg.state)
            VLS_S_IDLE: begin
                if (start_req) begin
                    if (!cfg_ok) begin
                        st_next.bad_cfg = 1'b1; // R3
                    end else if (align_bad) begin
                        st_next.align_fault = 1'b1; // R19
                    end else begin
                        st_next.state = VLS_S_PREP;
                        st_next.addr = st_reg.base; // R16
                        st_next.xbase = st_reg.base;
                        st_next.b = 3'h0;
                        st_next.j = 2'h0;
                        st_next.i = 3'h0;
                        st_next.grp = 2'h0;
                        st_next.cnt = 6'h00;
                        st_next.acks = 6'h00;
                    end
                end
            end
            VLS_S_PREP: begin
                // one byte is staged per access so the write data leaves a flop
                st_next.wbyte = st_reg.vreg[cur_reg][bitpos +: 8]; // R15
                st_next.state = VLS_S_XFER;
            end
            VLS_S_XFER: begin
                if (mem_ack) begin
                    if (!op_store) begin
                        if (is_struct && lmode == VLS_LANE_REPL) begin
                            for (int l = 0; l < 8; l++) begin
                                if (4'(l) < lanes) begin
                                    st_next.vreg[cur_reg][{3'(4'(l) * s_bytes + 4'(eb)), 3'b000} +: 8] =
                                        mem_rdata; // R13
                                end
                            end
                        end else begin
                            st_next.vreg[cur_reg][bitpos +: 8] = mem_rdata; // R12 R14 R4
                        end
                    end
                    st_next.acks = 6'(st_reg.acks + 6'h01);
                    st_next.addr = st_reg.addr + 32'h0000_0001; // R22
                    if (st_reg.cnt == 6'(total - 6'h01)) begin
                        st_next.state = VLS_S_DONE;
                    end else begin
                        st_next.cnt = 6'(st_reg.cnt + 6'h01);
                        st_next.state = VLS_S_PREP;
                        // byte, then element of the structure, then lane, then register group
                        if (4'(st_reg.b) == 4'(s_bytes - 4'h1)) begin
                            st_next.b = 3'h0;
                            if (3'(st_reg.j) == 3'(n_el - 3'h1)) begin
                                st_next.j = 2'h0; // R6 R7 R8 R9
                                if (4'(st_reg.i) == 4'(lanes - 4'h1)) begin
                                    st_next.i = 3'h0;
                                    st_next.grp = 2'(st_reg.grp + 2'h1);
                                end else begin
                                    st_next.i = 3'(st_reg.i + 3'h1);
                                end
                            end else begin
                                st_next.j = 2'(st_reg.j + 2'h1);
                            end
                        end else begin
                            st_next.b = 3'(st_reg.b + 3'h1);
                        end
                    end
                end
            end
            VLS_S_DONE: begin
                case (amode)
                    VLS_AM_INC: st_next.base = st_reg.xbase + 32'(total); // R17
                    VLS_AM_POST: st_next.base = st_reg.xbase + st_reg.index; // R18
                    default: st_next.base = st_reg.base; // R16
                endcase
                st_next.done = 1'b1;
                st_next.state = VLS_S_IDLE;
            end
            default: st_next.state = VLS_S_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.state <= VLS_S_IDLE;
            st_reg.cfg <= VLS_CFG_RST;
            st_reg.base <= VLS_BASE_RST;
            st_reg.index <= VLS_INDEX_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking vls_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_req_hold: assert property ( // R22
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
        else $error("memory request dropped or changed before ack");
    chk_addr_step: assert property ( // R22
        mem_req && mem_ack |=> mem_addr == $past(mem_addr) + 32'h0000_0001)
        else $error("memory address did not step by one byte");
    chk_first_addr: assert property ( // R16
        st_reg.state == VLS_S_IDLE && start_req && cfg_ok && !align_bad
        |=> ##1 mem_req && mem_addr == $past(st_reg.base, 2))
        else $error("first access not at base address");
    chk_plain_base: assert property ( // R16
        st_reg.state == VLS_S_DONE && amode == VLS_AM_PLAIN |=> st_reg.base == $past(st_reg.xbase))
        else $error("plain addressing changed the base");
    chk_inc_base: assert property ( // R17
        st_reg.state == VLS_S_DONE && amode == VLS_AM_INC
        |=> st_reg.base == $past(st_reg.xbase) + 32'($past(total)))
        else $error("increment-after base wrong");
    chk_post_base: assert property ( // R18
        st_reg.state == VLS_S_DONE && amode == VLS_AM_POST
        |=> st_reg.base == $past(st_reg.xbase) + $past(st_reg.index))
        else $error("post-index base wrong");
    chk_byte_total: assert property ( // R4
        st_reg.state == VLS_S_DONE |-> st_reg.acks == total ##1 st_reg.done)
        else $error("byte count differs from transfer size");
    chk_bad_refused: assert property ( // R3
        st_reg.state == VLS_S_IDLE && start_req && !cfg_ok |=> st_reg.bad_cfg && !mem_req ##1 !mem_req)
        else $error("invalid configuration was not refused");
    chk_align_refused: assert property ( // R19
        st_reg.state == VLS_S_IDLE && start_req && cfg_ok && align_bad
        |=> st_reg.align_fault && st_reg.state == VLS_S_IDLE)
        else $error("misaligned base was not refused");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    cov_triple_load: cover property (st_reg.state == VLS_S_DONE && is_struct && pat == 2'h2 && !op_store);
    cov_one_lane: cover property (st_reg.state == VLS_S_DONE && lmode == VLS_LANE_ONE);
    cov_post_store: cover property (st_reg.state == VLS_S_DONE && amode == VLS_AM_POST && op_store);
    cov_block: cover property (st_reg.state == VLS_S_DONE && kind == VLS_KIND_BLOCK && nregs == 3'h4);

endmodule // vls_unit

`default_nettype wire

// [hdl/vls_pkg.sv]
// constants, field layout and types for the vector structure load/store unit
package vls_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] VLS_OFF_CFG = 8'h00;
    localparam logic [7:0] VLS_OFF_START = 8'h04;
    localparam logic [7:0] VLS_OFF_STATUS = 8'h08;
    localparam logic [7:0] VLS_OFF_BASE = 8'h0C;
    localparam logic [7:0] VLS_OFF_INDEX = 8'h10;
    localparam logic [7:0] VLS_OFF_VSEL = 8'h14;
    localparam logic [7:0] VLS_OFF_VLO = 8'h18;
    localparam logic [7:0] VLS_OFF_VHI = 8'h1C;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CFG_STORE = 0;
    localparam int CFG_KIND_LSB = 1;
    localparam int CFG_PAT_LSB = 3;
    localparam int CFG_SIZE_LSB = 5;
    localparam int CFG_LANE_LSB = 7;
    localparam int CFG_LIDX_LSB = 9;
    localparam int CFG_CNT_LSB = 12;
    localparam int CFG_AMODE_LSB = 14;
    localparam int CFG_ALIGN_LSB = 16;
    localparam int CFG_BIGEND = 19;
    localparam int CFG_FIRST_LSB = 20;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ALIGN = 2;
    localparam int ST_BAD = 3;

    // ****************************************
    // reset values and sizes
    // ****************************************
    localparam logic [31:0] VLS_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] VLS_BASE_RST = 32'h0000_0000;
    localparam logic [31:0] VLS_INDEX_RST = 32'h0000_0000;
    localparam int VLS_NUM_VREG = 16;
    localparam int VLS_VREG_BITS = 64;
    localparam logic [1:0] VLS_RESP_OKAY = 2'h0;
    localparam logic [1:0] VLS_RESP_SLVERR = 2'h2;

    // ****************************************
    // enumerations
    // ****************************************
    typedef enum logic [1:0] {
        VLS_KIND_STRUCT = 2'b00,
        VLS_KIND_SINGLE = 2'b01,
        VLS_KIND_BLOCK = 2'b10
    } vls_kind_t;

    typedef enum logic [1:0] {
        VLS_LANE_ALL = 2'b00,
        VLS_LANE_REPL = 2'b01,
        VLS_LANE_ONE = 2'b10
    } vls_lane_t;

    typedef enum logic [1:0] {
        VLS_AM_PLAIN = 2'b00,
        VLS_AM_INC = 2'b01,
        VLS_AM_POST = 2'b10
    } vls_amode_t;

    typedef enum logic [1:0] {
        VLS_S_IDLE = 2'b00,
        VLS_S_PREP = 2'b01,
        VLS_S_XFER = 2'b10,
        VLS_S_DONE = 2'b11
    } vls_state_e_t;

endpackage

// [tb/vls_mem_model.sv]
// byte-wide memory model facing the unit's memory port
`timescale 1ns/100ps
`default_nettype none

module vls_mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic ack
);
    logic [7:0] mem [256];
    int wait_cnt = 0;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0];
        rdata = 8'h00;
        ack = 1'b0;
    end
    // odd addresses answer late, so prompt and slow replies both occur
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~rdata; // idle bus never repeats the last byte
        if (req && !ack) begin
            if (wait_cnt < (addr[0] ? 2 : 0)) begin
                wait_cnt <= wait_cnt + 1;
            end else begin
                wait_cnt <= 0;
                ack <= 1'b1;
                rdata <= mem[addr[7:0]];
                if (we) mem[addr[7:0]] <= wdata;
            end
        end
    end
endmodule // vls_mem_model

`default_nettype wire

// [tb/vls_unit_test.sv]
// self-checking testbench for the vector structure load/store unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end

module vls_unit_test;
    import vls_pkg::*;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, mem_req, mem_we, mem_ack;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, mem_wdata, mem_rdata;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_addr, d, st;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int mismatches = 0, num_checks = 0;
    // cfg, vector select, low word, high word, base after the transfer
    logic [31:0] rows [7][5] = '{
        '{32'h0000_1028, 32'h0, 32'h2524_2120, 32'h2D2C_2928, 32'h20},
        '{32'h0020_5048, 32'h2, 32'h2322_2120, 32'h2B2A_2928, 32'h30},
        '{32'h0040_A010, 32'h5, 32'h2A27_2421, 32'h3633_302D, 32'h120},
        '{32'h0082_3018, 32'hB, 32'h2F2B_2723, 32'h3F3B_3733, 32'h20},
        '{32'h00C8_0020, 32'hC, 32'h2223_2021, 32'h2627_2425, 32'h20},
        '{32'h00D0_0002, 32'hD, 32'h2322_2120, 32'h2726_2524, 32'h20},
        '{32'h00E0_1004, 32'hF, 32'h2B2A_2928, 32'h2F2E_2D2C, 32'h20}};

    vls_unit vls_unit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    vls_mem_model vls_mem_model_i (.clk(aclk), .req(mem_req), .we(mem_we), .addr(mem_addr),
        .wdata(mem_wdata), .rdata(mem_rdata), .ack(mem_ack));

    always #20 aclk = ~aclk;

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // start a transfer and poll until it ends; polls are bounded
    task automatic run(input logic [31:0] cfg, input logic [31:0] base);
        int n;
        n = 0;
        wr(VLS_OFF_BASE, base);
        wr(VLS_OFF_CFG, cfg);
        wr(VLS_OFF_START, 32'h1);
        do begin
            rd(VLS_OFF_STATUS);
            st = d;
            n++;
        end while (st[3:1] === 3'b000 && n < 100);
        if (st[3:1] === 3'b000) mismatches++;
        wr(VLS_OFF_STATUS, 32'hE);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(40 * 30000);
        mismatches++;
        end_sim;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(VLS_OFF_CFG);
        `CHK(d, VLS_CFG_RST)
        `CHK(r, VLS_RESP_OKAY)
        wr(VLS_OFF_INDEX, 32'h100);
        `CHK(r, VLS_RESP_OKAY)
        for (int k = 0; k < 7; k++) begin
            run(rows[k][0], 32'h20);
            `CHK(st[ST_DONE], 1'b1)
            rd(VLS_OFF_BASE);
            `CHK(d, rows[k][4])
            wr(VLS_OFF_VSEL, rows[k][1]);
            rd(VLS_OFF_VLO);
            `CHK(d, rows[k][2])
            rd(VLS_OFF_VHI);
            `CHK(d, rows[k][3])
        end
        run(32'h0000_0300, 32'h40);
        wr(VLS_OFF_VSEL, 32'h0);
        rd(VLS_OFF_VLO);
        `CHK(d, 32'h2524_4020)
        run(32'h00E0_0080, 32'h40);
        wr(VLS_OFF_VSEL, 32'hE);
        rd(VLS_OFF_VHI);
        `CHK(d, 32'h4040_4040)
        run(32'h0040_A011, 32'h80);
        rd(VLS_OFF_BASE);
        `CHK(d, 32'h180)
        `CHK(vls_mem_model_i.mem[8'h81], 8'h21)
        `CHK(vls_mem_model_i.mem[8'h97], 8'h37)
        run(32'h0000_1010, 32'h20);
        `CHK(st[ST_BAD], 1'b1)
        run(32'h0000_0060, 32'h20);
        `CHK(st[ST_BAD], 1'b1)
        run(32'h0002_0000, 32'h21); // misaligned on purpose
        `CHK(st[ST_ALIGN], 1'b1)
        rd(8'h40);
        `CHK(r, VLS_RESP_SLVERR)
        wr(8'h40, 32'h0);
        `CHK(r, VLS_RESP_SLVERR)
        // reset while idle must bring back the base and configuration registers
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(VLS_OFF_BASE);
        `CHK(d, VLS_BASE_RST)
        rd(VLS_OFF_CFG);
        `CHK(d, VLS_CFG_RST)
        end_sim;
    end
endmodule // vls_unit_test

`default_nettype wire
